//--- shared/fer_pkg.sv
// Package with the register map, field positions, reset values and arithmetic constants of the estimator window.
package fer_pkg;

  localparam int FER_ADDR_W = 16;
  localparam int FER_DATA_W = 8;
  localparam int FER_WORD_W = 16;

  // Byte addresses; a 16-bit register puts its high byte here and its low byte one above.
  localparam logic [15:0] FER_SPEED_LIMIT_ADDR = 16'h406F;
  localparam logic [15:0] FER_ANGLE_ADDR       = 16'h40CE;
  localparam logic [15:0] FER_BEMF_ALPHA_ADDR  = 16'h40D0;
  localparam logic [15:0] FER_BEMF_BETA_ADDR   = 16'h40D2;
  localparam logic [15:0] FER_SPEED_ADDR       = 16'h40D4;
  localparam logic [15:0] FER_QOVF_ADDR        = 16'h40D6;
  localparam logic [15:0] FER_POWER_ADDR       = 16'h40D8;
  localparam logic [15:0] FER_PEAK_A_ADDR      = 16'h40DA;
  localparam logic [15:0] FER_PEAK_B_ADDR      = 16'h40DC;
  localparam logic [15:0] FER_PEAK_C_ADDR      = 16'h40DE;
  localparam logic [15:0] FER_CTRL_ADDR        = 16'h40E0;
  localparam logic [15:0] FER_HOLD_ADDR        = 16'h40E2;

  // Control register fields.
  localparam int FER_CTRL_HOLD_SEL_BIT = 0;
  localparam int FER_CTRL_PEAK_CLR_BIT = 1;

  // Reset values.
  localparam logic [7:0]  FER_SPEED_LIMIT_RST = 8'h7F;
  localparam logic [7:0]  FER_BYTE_RST        = 8'h00;
  localparam logic [15:0] FER_WORD_RST        = 16'h0000;
  localparam logic [31:0] FER_ACC_RST         = 32'h0000_0000;

  // Speed filter factor is k divided by 2 to the 15th.
  localparam int FER_FILT_SHIFT = 15;

  // Frequency-generator period used when the filtered speed is zero.
  localparam logic [15:0] FER_PERIOD_SAT = 16'hFFFF;

endpackage

//--- src/fer_peak_track.sv
// Peak tracker that records the largest sampled current of one phase.
`timescale 1ns/1ps
`default_nettype none

module fer_peak_track (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire logic               sample_i,
  input  wire logic signed [15:0] current_i,
  input  wire logic               clear_i,
  output var  logic        [15:0] peak_o
);
  import fer_pkg::*;

  logic signed [15:0] peak_reg;
  logic signed [15:0] peak_base;
  logic signed [15:0] peak_next;

  // A sample in the cycle of a clear is compared against zero, so it is not lost.
  assign peak_base = clear_i ? $signed(FER_WORD_RST) : peak_reg;
  assign peak_next = (sample_i && (current_i > peak_base)) ? current_i : peak_base;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      peak_reg <= FER_WORD_RST;
    end else begin
      peak_reg <= peak_next;
    end
  end

  assign peak_o = peak_reg;

endmodule

`default_nettype wire

//--- src/fer_est_regs.sv
// Estimator output register window: angle, back-EMF, speed clamp and filter, frequency generator, power, peaks.
`timescale 1ns/1ps
`default_nettype none

module fer_est_regs (
  input  wire logic                           ref_clk_i,
  input  wire logic                           rst_i,
  input  wire logic [fer_pkg::FER_ADDR_W-1:0] reg_addr_i,
  input  wire logic [fer_pkg::FER_DATA_W-1:0] reg_wdata_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  output var  logic [fer_pkg::FER_DATA_W-1:0] reg_rdata_o,
  input  wire logic                           pwm_cycle_i,
  input  wire logic [fer_pkg::FER_WORD_W-1:0] est_angle_i,
  input  wire logic [fer_pkg::FER_WORD_W-1:0] bemf_alpha_i,
  input  wire logic [fer_pkg::FER_WORD_W-1:0] bemf_beta_i,
  input  wire logic [fer_pkg::FER_WORD_W-1:0] raw_speed_i,
  input  wire logic [fer_pkg::FER_WORD_W-1:0] q_axis_controller_output_i,
  input  wire logic [fer_pkg::FER_WORD_W-1:0] q_axis_output_limit_i,
  input  wire logic [fer_pkg::FER_WORD_W-1:0] motor_power_i,
  input  wire logic [fer_pkg::FER_WORD_W-1:0] phase_a_current_i,
  input  wire logic [fer_pkg::FER_WORD_W-1:0] phase_b_current_i,
  input  wire logic [fer_pkg::FER_WORD_W-1:0] phase_c_current_i,
  output var  logic [fer_pkg::FER_WORD_W-1:0] start_angle_o,
  output var  logic                           start_angle_load_o,
  output var  logic [fer_pkg::FER_WORD_W-1:0] filtered_speed_o,
  output var  logic [fer_pkg::FER_WORD_W-1:0] output_timer_reload_o,
  output var  logic [fer_pkg::FER_WORD_W-1:0] output_timer_compare_o,
  output var  logic                           output_timer_update_o
);
  import fer_pkg::*;

  // True when a byte address falls on either byte of the 16-bit register at base.
  function automatic logic word_hit(input logic [15:0] addr, input logic [15:0] base);
    word_hit = (addr[15:1] == base[15:1]);
  endfunction

  // Picks the high byte on the even address and the low byte on the odd one.
  function automatic logic [7:0] byte_of(input logic [15:0] value, input logic low_sel);
    byte_of = low_sel ? value[7:0] : value[15:8];
  endfunction

  // Register state.
  logic [7:0]         speed_limit_reg;
  logic [15:0]        estimator_angle_reg;
  logic [7:0]         angle_stage_reg;
  logic [15:0]        bemf_alpha_estimate_reg;
  logic [15:0]        bemf_beta_estimate_reg;
  logic [15:0]        estimator_speed_reg;
  logic [15:0]        q_axis_overflow_reg;
  logic [15:0]        tach_output_coeff_reg;
  logic [15:0]        motor_power_reg;
  logic [7:0]         speed_filter_coeff_reg;
  logic               limit_hold_select_reg;
  logic [15:0]        hold_speed_value_reg;
  logic signed [31:0] filt_acc_reg;
  logic [7:0]         rdata_reg;
  logic [15:0]        start_angle_reg;
  logic               start_angle_load_reg;
  logic [15:0]        timer_reload_reg;
  logic [15:0]        timer_compare_reg;
  logic               timer_update_reg;

  // Address decode.
  logic low_sel;
  logic wr_limit;
  logic wr_angle;
  logic wr_speed;
  logic wr_coeff;
  logic wr_filt;
  logic wr_ctrl;
  logic wr_hold;

  assign low_sel  = reg_addr_i[0];
  assign wr_limit = reg_wr_i && (reg_addr_i == FER_SPEED_LIMIT_ADDR);
  assign wr_angle = reg_wr_i && word_hit(reg_addr_i, FER_ANGLE_ADDR);
  assign wr_speed = reg_wr_i && word_hit(reg_addr_i, FER_SPEED_ADDR);
  assign wr_coeff = reg_wr_i && word_hit(reg_addr_i, FER_QOVF_ADDR);
  assign wr_filt  = reg_wr_i && (reg_addr_i == FER_POWER_ADDR);
  assign wr_ctrl  = reg_wr_i && (reg_addr_i == FER_CTRL_ADDR);
  assign wr_hold  = reg_wr_i && word_hit(reg_addr_i, FER_HOLD_ADDR);

  // Peak clear is a write of one to the clear bit; the bit itself is not stored.
  logic peak_clear;
  assign peak_clear = wr_ctrl && reg_wdata_i[FER_CTRL_PEAK_CLR_BIT];

  // Speed clamp on the raw estimator speed.
  logic signed [7:0] speed_high;
  logic signed [7:0] limit_signed;
  logic              limit_enabled;
  logic              speed_over;
  logic [15:0]       limited_output_speed;

  assign speed_high    = $signed(raw_speed_i[15:8]);
  assign limit_signed  = $signed({1'b0, speed_limit_reg[6:0]});
  assign limit_enabled = ~speed_limit_reg[7];
  assign speed_over    = limit_enabled && (speed_high > limit_signed);
  assign limited_output_speed = !speed_over ? raw_speed_i :
                                limit_hold_select_reg ? hold_speed_value_reg :
                                {speed_limit_reg, 8'h00};

  // Speed low-pass filter kept at 15 fractional bits so that small factors still make progress.
  logic signed [31:0] filt_target;
  logic signed [32:0] filt_err;
  logic signed [41:0] filt_prod;
  logic signed [31:0] filt_step;
  logic signed [31:0] filt_acc_next;
  logic        [15:0] filtered_speed;

  assign filt_target   = $signed({estimator_speed_reg[15], estimator_speed_reg, 15'h0000});
  assign filt_err      = $signed({filt_target[31], filt_target}) - $signed({filt_acc_reg[31], filt_acc_reg});
  assign filt_prod     = filt_err * $signed({1'b0, speed_filter_coeff_reg});
  assign filt_step     = {{5{filt_prod[41]}}, filt_prod[41:FER_FILT_SHIFT]};
  assign filt_acc_next = filt_acc_reg + filt_step;
  assign filtered_speed = filt_acc_reg[30:15];

  // Frequency-generator period: coefficient over the filtered speed magnitude.
  logic [15:0] speed_mag;
  logic [15:0] fg_period;
  logic        fg_enabled;

  assign speed_mag  = filtered_speed[15] ? 16'(-filtered_speed) : filtered_speed;
  assign fg_period  = (speed_mag == FER_WORD_RST) ? FER_PERIOD_SAT : 16'(tach_output_coeff_reg / speed_mag);
  assign fg_enabled = pwm_cycle_i && (tach_output_coeff_reg != FER_WORD_RST);

  // Overflow of the q-axis controller, saturated so a wide swing does not wrap its sign.
  logic signed [16:0] qovf_diff;
  logic        [15:0] qovf_sat;

  assign qovf_diff = $signed({q_axis_controller_output_i[15], q_axis_controller_output_i})
                   - $signed({q_axis_output_limit_i[15], q_axis_output_limit_i});
  assign qovf_sat  = (qovf_diff[16] == qovf_diff[15]) ? qovf_diff[15:0] :
                     (qovf_diff[16] ? 16'h8000 : 16'h7FFF);

  // Peak trackers, one per phase.
  logic [15:0] phase_current [3];
  logic [15:0] phase_peak    [3];

  assign phase_current[0] = phase_a_current_i;
  assign phase_current[1] = phase_b_current_i;
  assign phase_current[2] = phase_c_current_i;

  generate
    for (genvar ph = 0; ph < 3; ph++) begin : g_peak
      fer_peak_track u_peak (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .sample_i  (pwm_cycle_i),
        .current_i ($signed(phase_current[ph])),
        .clear_i   (peak_clear),
        .peak_o    (phase_peak[ph])
      );
    end
  endgenerate

  // Read selection; unmapped addresses read as zero, and write-only halves read the estimator word at the same address.
  logic [7:0] ctrl_read;
  logic [7:0] rdata_next;

  assign ctrl_read  = {7'h00, limit_hold_select_reg};
  assign rdata_next = !reg_rd_i ? FER_BYTE_RST :
    (reg_addr_i == FER_SPEED_LIMIT_ADDR)       ? speed_limit_reg :
    word_hit(reg_addr_i, FER_ANGLE_ADDR)       ? byte_of(estimator_angle_reg, low_sel) :
    word_hit(reg_addr_i, FER_BEMF_ALPHA_ADDR)  ? byte_of(bemf_alpha_estimate_reg, low_sel) :
    word_hit(reg_addr_i, FER_BEMF_BETA_ADDR)   ? byte_of(bemf_beta_estimate_reg, low_sel) :
    word_hit(reg_addr_i, FER_SPEED_ADDR)       ? byte_of(estimator_speed_reg, low_sel) :
    word_hit(reg_addr_i, FER_QOVF_ADDR)        ? byte_of(q_axis_overflow_reg, low_sel) :
    word_hit(reg_addr_i, FER_POWER_ADDR)       ? byte_of(motor_power_reg, low_sel) :
    word_hit(reg_addr_i, FER_PEAK_A_ADDR)      ? byte_of(phase_peak[0], low_sel) :
    word_hit(reg_addr_i, FER_PEAK_B_ADDR)      ? byte_of(phase_peak[1], low_sel) :
    word_hit(reg_addr_i, FER_PEAK_C_ADDR)      ? byte_of(phase_peak[2], low_sel) :
    (reg_addr_i == FER_CTRL_ADDR)              ? ctrl_read :
    word_hit(reg_addr_i, FER_HOLD_ADDR)        ? byte_of(hold_speed_value_reg, low_sel) :
    FER_BYTE_RST;

  // Software configuration registers.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      speed_limit_reg        <= FER_SPEED_LIMIT_RST;
      speed_filter_coeff_reg <= FER_BYTE_RST;
      limit_hold_select_reg  <= 1'b0;
    end else begin
      if (wr_limit) begin
        speed_limit_reg <= reg_wdata_i;
      end
      if (wr_filt) begin
        speed_filter_coeff_reg <= reg_wdata_i;
      end
      if (wr_ctrl) begin
        limit_hold_select_reg <= reg_wdata_i[FER_CTRL_HOLD_SEL_BIT];
      end
    end
  end

  // Sixteen-bit software words written one byte at a time, high byte at the even address.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tach_output_coeff_reg <= FER_WORD_RST;
      hold_speed_value_reg  <= FER_WORD_RST;
    end else begin
      if (wr_coeff && !low_sel) begin
        tach_output_coeff_reg[15:8] <= reg_wdata_i;
      end
      if (wr_coeff && low_sel) begin
        tach_output_coeff_reg[7:0] <= reg_wdata_i;
      end
      if (wr_hold && !low_sel) begin
        hold_speed_value_reg[15:8] <= reg_wdata_i;
      end
      if (wr_hold && low_sel) begin
        hold_speed_value_reg[7:0] <= reg_wdata_i;
      end
    end
  end

  // Start angle: the high byte waits in a stage until the low byte completes the word.
  // Writing the low byte alone reuses the last staged high byte.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      angle_stage_reg      <= FER_BYTE_RST;
      start_angle_reg      <= FER_WORD_RST;
      start_angle_load_reg <= 1'b0;
    end else begin
      start_angle_load_reg <= wr_angle && low_sel;
      if (wr_angle && !low_sel) begin
        angle_stage_reg <= reg_wdata_i;
      end
      if (wr_angle && low_sel) begin
        start_angle_reg <= {angle_stage_reg, reg_wdata_i};
      end
    end
  end

  // Estimator results captured once per PWM cycle so both bytes of a word stay consistent within a cycle.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      estimator_angle_reg     <= FER_WORD_RST;
      bemf_alpha_estimate_reg <= FER_WORD_RST;
      bemf_beta_estimate_reg  <= FER_WORD_RST;
      motor_power_reg         <= FER_WORD_RST;
      q_axis_overflow_reg     <= FER_WORD_RST;
    end else if (pwm_cycle_i) begin
      estimator_angle_reg     <= est_angle_i;
      bemf_alpha_estimate_reg <= bemf_alpha_i;
      bemf_beta_estimate_reg  <= bemf_beta_i;
      motor_power_reg         <= motor_power_i;
      q_axis_overflow_reg     <= qovf_sat;
    end
  end

  // Output speed: the PWM update wins over a software write in the same cycle.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      estimator_speed_reg <= FER_WORD_RST;
    end else if (pwm_cycle_i) begin
      estimator_speed_reg <= limited_output_speed;
    end else if (wr_speed && !low_sel) begin
      estimator_speed_reg[15:8] <= reg_wdata_i;
    end else if (wr_speed && low_sel) begin
      estimator_speed_reg[7:0] <= reg_wdata_i;
    end
  end

  // Speed filter state.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_acc_reg <= FER_ACC_RST;
    end else if (pwm_cycle_i) begin
      filt_acc_reg <= filt_acc_next;
    end
  end

  // Frequency-generator timer loads.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_reload_reg  <= FER_WORD_RST;
      timer_compare_reg <= FER_WORD_RST;
      timer_update_reg  <= 1'b0;
    end else begin
      timer_update_reg <= fg_enabled;
      if (fg_enabled) begin
        timer_reload_reg  <= fg_period;
        timer_compare_reg <= {1'b0, fg_period[15:1]};
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= FER_BYTE_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Filtered speed is registered once more so the output port comes straight from a flip-flop.
  logic [15:0] filtered_speed_reg;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      filtered_speed_reg <= FER_WORD_RST;
    end else begin
      filtered_speed_reg <= filtered_speed;
    end
  end

  assign reg_rdata_o            = rdata_reg;
  assign start_angle_o          = start_angle_reg;
  assign start_angle_load_o     = start_angle_load_reg;
  assign filtered_speed_o       = filtered_speed_reg;
  assign output_timer_reload_o  = timer_reload_reg;
  assign output_timer_compare_o = timer_compare_reg;
  assign output_timer_update_o  = timer_update_reg;

endmodule

`default_nettype wire

//--- tb/fer_est_regs_chk.sv
// Checker of the port timing of the estimator register window.
`timescale 1ns/1ps
`default_nettype none

module fer_est_regs_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        pwm_cycle_i,
  input wire logic [15:0] start_angle_o,
  input wire logic        start_angle_load_o,
  input wire logic [15:0] filtered_speed_o,
  input wire logic [15:0] output_timer_reload_o,
  input wire logic [15:0] output_timer_compare_o,
  input wire logic        output_timer_update_o
);
  import fer_pkg::*;
  wire lo_wr = reg_wr_i && reg_addr_i == FER_ANGLE_ADDR + 16'h0001;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  property p_lo_load; lo_wr |=> start_angle_load_o && start_angle_o[7:0] == $past(reg_wdata_i); endproperty
  property p_load_cause; start_angle_load_o |-> $past(lo_wr); endproperty
  property p_start_hold; !start_angle_load_o |-> $stable(start_angle_o); endproperty
  property p_upd_cause; output_timer_update_o |-> $past(pwm_cycle_i); endproperty
  property p_cmp_half;
    output_timer_update_o |-> output_timer_compare_o == {1'b0, output_timer_reload_o[15:1]};
  endproperty
  property p_tim_hold;
    !$past(pwm_cycle_i) |-> $stable(output_timer_reload_o) && $stable(output_timer_compare_o);
  endproperty
  property p_filt_hold; !$past(pwm_cycle_i, 2) |-> $stable(filtered_speed_o); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
  a_lo_load: assert property (p_lo_load) else $error("start angle not loaded after low byte");
  a_load_cause: assert property (p_load_cause) else $error("start angle load without a write");
  a_start_hold: assert property (p_start_hold) else $error("start angle moved without a load");
  a_upd_cause: assert property (p_upd_cause) else $error("timer update without a PWM cycle");
  a_cmp_half: assert property (p_cmp_half) else $error("timer compare is not half the reload");
  a_tim_hold: assert property (p_tim_hold) else $error("timer values moved between PWM cycles");
  a_filt_hold: assert property (p_filt_hold) else $error("filtered speed moved between PWM cycles");
  c_load: cover property (lo_wr ##1 start_angle_load_o);
  c_update: cover property (pwm_cycle_i ##1 output_timer_update_o);
  c_read: cover property (reg_rd_i ##1 reg_rdata_o != 8'h00);
endmodule

bind fer_est_regs fer_est_regs_chk fer_est_regs_chk_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .pwm_cycle_i(pwm_cycle_i), .start_angle_o(start_angle_o),
  .start_angle_load_o(start_angle_load_o), .filtered_speed_o(filtered_speed_o),
  .output_timer_reload_o(output_timer_reload_o), .output_timer_compare_o(output_timer_compare_o),
  .output_timer_update_o(output_timer_update_o));
`default_nettype wire

//--- tb/fer_est_regs_test.sv
// Self-checking testbench of the estimator register window.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module fer_est_regs_test;
  import fer_pkg::*;
  logic        ref_clk_i, rst_i, reg_wr_i, reg_rd_i, pwm_cycle_i, rd_pend, load_o, update_o;
  logic [15:0] reg_addr_i, est_angle_i, bemf_alpha_i, bemf_beta_i, raw_speed_i, uq_i, qmax_i, power_i;
  logic [15:0] cur_a_i, cur_b_i, cur_c_i, start_angle_o, filt_o, reload_o, compare_o;
  logic [7:0]  reg_wdata_i, reg_rdata_o, em8, k_m;
  logic [15:0] em16, rnd_state, spd_m, coeff_m;
  logic [15:0] v[7];
  logic [7:0]  rq[$];
  logic [15:0] tq[$];
  longint      acc_m;
  int          err_count, n_checks;
  logic [7:0]  lim_t[6] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h00, 8'h90};
  logic [15:0] raw_t[6] = '{16'h2345, 16'h10FF, 16'h8000, 16'h2345, 16'h0100, 16'h7FFF};
  logic [15:0] exp_t[6] = '{16'h1000, 16'h10FF, 16'h8000, 16'h0ABC, 16'h0000, 16'h7FFF};

  fer_est_regs fer_est_regs_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pwm_cycle_i(pwm_cycle_i),
    .est_angle_i(est_angle_i), .bemf_alpha_i(bemf_alpha_i), .bemf_beta_i(bemf_beta_i), .raw_speed_i(raw_speed_i),
    .q_axis_controller_output_i(uq_i), .q_axis_output_limit_i(qmax_i), .motor_power_i(power_i),
    .phase_a_current_i(cur_a_i), .phase_b_current_i(cur_b_i), .phase_c_current_i(cur_c_i),
    .start_angle_o(start_angle_o), .start_angle_load_o(load_o), .filtered_speed_o(filt_o),
    .output_timer_reload_o(reload_o), .output_timer_compare_o(compare_o), .output_timer_update_o(update_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [15:0] rnd();
    rnd_state ^= rnd_state << 7;
    rnd_state ^= rnd_state >> 9;
    rnd_state ^= rnd_state << 8;
    return rnd_state;
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Reads both bytes of a word, high byte first, and notes what each should return.
  task automatic rd16(input logic [15:0] a, input logic [15:0] x);
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk_i);
      reg_addr_i <= a + 16'(i);
      reg_rd_i <= 1'b1;
      rq.push_back(i == 0 ? x[15:8] : x[7:0]);
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
    end
  endtask

  // One PWM cycle; the model uses the speed and filter state from before the pulse.
  task automatic pwm(input logic [15:0] raw, input logic [15:0] spd);
    int fa;
    fa = int'($signed(acc_m[30:15]));
    fa = fa < 0 ? -fa : fa;
    @(posedge ref_clk_i);
    raw_speed_i <= raw;
    pwm_cycle_i <= 1'b1;
    if (coeff_m != 16'h0000) tq.push_back(fa == 0 ? 16'hFFFF : 16'(int'(coeff_m) / fa));
    acc_m += (((longint'($signed(spd_m)) <<< 15) - acc_m) * longint'(k_m)) >>> 15;
    spd_m = spd;
    @(posedge ref_clk_i);
    pwm_cycle_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask

  always @(posedge ref_clk_i) begin
    rd_pend <= reg_rd_i;
    if (rd_pend) begin
      em8 = rq.pop_front();
      `CHK("read data", em8, reg_rdata_o)
    end
    if (update_o) begin
      em16 = tq.size() > 0 ? tq.pop_front() : 16'hxxxx;
      `CHK("timer reload", em16, reload_o)
      `CHK("timer compare", em16 >> 1, compare_o)
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk_i);
    err_count++;
    end_sim();
  end

  initial begin
    rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, pwm_cycle_i, reg_wdata_i, k_m} = '0;
    {reg_addr_i, est_angle_i, bemf_alpha_i, bemf_beta_i, raw_speed_i, uq_i, qmax_i, power_i} = '0;
    {cur_a_i, cur_b_i, cur_c_i, spd_m, coeff_m} = '0;
    acc_m = 0;
    rnd_state = 16'h0050;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd16(FER_SPEED_LIMIT_ADDR, 16'h7F00);
    for (int a = 16'h40CE; a < 16'h40E4; a += 2) rd16(16'(a), 16'h0000);
    $display("reset values done");
    wr(FER_SPEED_ADDR, 8'h12);
    wr(FER_SPEED_ADDR + 16'h0001, 8'h34);
    rd16(FER_SPEED_ADDR, 16'h1234);
    spd_m = 16'h1234;
    for (int n = 0; n < 3; n++) begin
      foreach (v[i]) v[i] = rnd();
      v[4] = {{2{v[4][13]}}, v[4][13:0]};
      v[5] = {{2{v[5][13]}}, v[5][13:0]};
      est_angle_i <= v[0];
      bemf_alpha_i <= v[1];
      bemf_beta_i <= v[2];
      power_i <= v[3];
      uq_i <= v[4];
      qmax_i <= v[5];
      pwm(v[6], v[6]);
      rd16(FER_ANGLE_ADDR, v[0]);
      rd16(FER_BEMF_ALPHA_ADDR, v[1]);
      rd16(FER_BEMF_BETA_ADDR, v[2]);
      rd16(FER_POWER_ADDR, v[3]);
      rd16(FER_QOVF_ADDR, v[4] - v[5]);
      rd16(FER_SPEED_ADDR, v[6]);
    end
    $display("capture done");
    wr(FER_ANGLE_ADDR, 8'hA5);
    wr(FER_ANGLE_ADDR + 16'h0001, 8'h3C);
    #1 `CHK("start angle", 16'hA53C, start_angle_o)
    `CHK("start load", 1'b1, load_o)
    rd16(FER_ANGLE_ADDR, v[0]);
    $display("start angle done");
    wr(FER_HOLD_ADDR, 8'h0A);
    wr(FER_HOLD_ADDR + 16'h0001, 8'hBC);
    for (int i = 0; i < 6; i++) begin
      wr(FER_SPEED_LIMIT_ADDR, lim_t[i]);
      wr(FER_CTRL_ADDR, {7'h00, i == 3 || i == 5});
      pwm(raw_t[i], exp_t[i]);
      rd16(FER_SPEED_ADDR, exp_t[i]);
    end
    rd16(FER_SPEED_LIMIT_ADDR, 16'h9000);
    $display("speed clamp done");
    wr(FER_POWER_ADDR, 8'hFF);
    k_m = 8'hFF;
    // Software keeps the coefficient inside its 16-bit range, so no prescaler change is needed.
    coeff_m = rnd() | 16'h8000;
    wr(FER_QOVF_ADDR, coeff_m[15:8]);
    wr(FER_QOVF_ADDR + 16'h0001, coeff_m[7:0]);
    rd16(FER_QOVF_ADDR, v[4] - v[5]);
    rd16(FER_POWER_ADDR, v[3]);
    repeat (12) pwm(16'h4000, 16'h4000);
    `CHK("filtered speed", 16'(acc_m >>> 15), filt_o)
    wr(FER_QOVF_ADDR, 8'h00);
    wr(FER_QOVF_ADDR + 16'h0001, 8'h00);
    coeff_m = 16'h0000;
    repeat (2) pwm(16'h4000, 16'h4000);
    $display("filter and timer done");
    cur_a_i <= 16'h0100;
    cur_b_i <= 16'h0200;
    cur_c_i <= 16'hFF00;
    pwm(16'h4000, 16'h4000);
    cur_a_i <= 16'h0050;
    cur_b_i <= 16'h0300;
    cur_c_i <= 16'h0010;
    pwm(16'h4000, 16'h4000);
    rd16(FER_PEAK_A_ADDR, 16'h0100);
    rd16(FER_PEAK_B_ADDR, 16'h0300);
    rd16(FER_PEAK_C_ADDR, 16'h0010);
    wr(FER_CTRL_ADDR, 8'h02);
    for (int a = 16'h40DA; a < 16'h40E0; a += 2) rd16(16'(a), 16'h0000);
    $display("peak records done");
    repeat (3) @(posedge ref_clk_i);
    `CHK("timer updates left", 32'd0, 32'(tq.size()))
    end_sim();
  end
endmodule
`default_nettype wire
